//--- core/emau_pkg.sv
/*
 * emau_pkg: register map, field positions, reset values, counts and carrier
 * structs of the E1 maintenance and alarm unit.
 * Assumes an 8-bit paged register port and a framer that delivers slot bytes.
 */
`default_nettype none
package emau_pkg;
	// register pages
	localparam logic [3:0] PG_CTL = 4'h1;
	localparam logic [3:0] PG_ERR = 4'h2;
	localparam logic [3:0] PG_STAT = 4'h4;
	localparam logic [3:0] PG_SLOT = 4'h7;
	localparam logic [3:0] PG_TXB0 = 4'h9;
	localparam logic [3:0] PG_TXB1 = 4'hA;
	localparam logic [3:0] PG_RXB0 = 4'hB;
	localparam logic [3:0] PG_RXB1 = 4'hC;
	// register offsets within a page
	localparam logic [4:0] A_MODE = 5'h11;
	localparam logic [4:0] A_INSERT = 5'h17;
	localparam logic [4:0] A_DETECT = 5'h18;
	localparam logic [4:0] A_DMASK = 5'h19;
	localparam logic [4:0] A_MASK3 = 5'h1E;
	localparam logic [4:0] A_ERRINS = 5'h10;
	localparam logic [4:0] A_BUFCTL = 5'h12;
	localparam logic [4:0] A_VECTOR = 5'h12;
	localparam logic [4:0] A_RECNT = 5'h19;
	localparam logic [4:0] A_ALARMS = 5'h10;
	// mode register fields
	localparam int MODE_TALM = 5;
	localparam int MODE_AUTO_REMOTE_ALARM_N_N = 4;
	localparam int MODE_AUTO_MULTIFRAME_ALARM_N_N = 3;
	localparam int MODE_TY = 2;
	localparam int MODE_AIS2 = 1;
	// error insertion fields
	localparam int ERR_BPV = 4;
	localparam int ERR_CRC = 3;
	localparam int ERR_FAS = 2;
	localparam int ERR_NFAS = 1;
	localparam int ERR_LOS = 0;
	// per-slot control fields; buffer b uses bit SC_RXB0+b and SC_TXB0+b
	localparam int SC_INSERT = 7;
	localparam int SC_DETECT = 6;
	localparam int SC_RXB0 = 0;
	localparam int SC_TXB0 = 2;
	// buffer accumulate control: buffer b at BUFFER_ZERO_START_SELECT-2b, BUFFER_ZERO_STOP_SELECT-2b; mismatch one below
	localparam int BC_BUFFER_ZERO_START_SELECT = 7;
	localparam int BC_BUFFER_ZERO_STOP_SELECT = 3;
	// mask word three and vector fields
	localparam int M3_STOP = 2;
	localparam int M3_START = 1;
	localparam int M3_DATA = 0;
	localparam int VEC_ALARM = 6;
	localparam int VEC_CIND = 5;
	localparam int VEC_COVF = 4;
	localparam int VEC_MAINT = 1;
	// reset values
	localparam logic [7:0] RST_MODE = 8'h18;
	localparam logic [7:0] RST_MASK3 = 8'h00;
	// counts in line bits
	localparam logic [10:0] AIS_BITS_1 = 11'h200;
	localparam logic [10:0] AIS_BITS_2 = 11'h400;
	localparam logic [10:0] AUX_BITS = 11'h200;
	localparam logic [7:0] LOS_BITS = 8'hFF;
	localparam logic [7:0] LOS_MIN_ONES = 8'(({24'h0, LOS_BITS} + 32'h7) >> 3);
	localparam logic [4:0] SLOT_SIG = 5'h10;
	localparam logic [7:0] RECNT_MAX = 8'hFF;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] page;
		logic [4:0] addr;
		logic [7:0] wdata;
	} emau_regreq_s;

	typedef struct packed {
		logic valid;
		logic [4:0] slot;
		logic [3:0] frame;
		logic [7:0] data;
	} emau_rxslot_s;

	typedef struct packed {
		logic remote;
		logic ais;
		logic ais16;
		logic los;
		logic aux;
		logic remote_mf;
	} emau_alarm_s;
endpackage : emau_pkg
`default_nettype wire

//--- core/emau_top.sv
/*
 * emau_top: remote error counting, error insertion, circular slot buffers,
 * slot code insert/detect, receive alarms, automatic alarms, category vector,
 * and the transmit byte FIFO (emau_fifo).
 * Assumes slot/frame strobes come from framer logic on mclk_i; the line clock
 * and pulse pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none

// byte FIFO; depth must be a power of two
module emau_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} emau_fifo_s;
	emau_fifo_s q, n;

	// extra pointer bit separates full from empty
	assign in_ready_o = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
	assign out_valid_o = (q.wp != q.rp);
	assign out_data_o = q.mem[q.rp[AW-1:0]];

	always_comb begin
		n = q;
		if (in_valid_i && in_ready_o) begin
			n.mem[q.wp[AW-1:0]] = in_data_i;
			n.wp = q.wp + 1'b1;
		end
		if (out_valid_o && out_ready_i) begin
			n.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule : emau_fifo

// Notes on behaviour
// - count errored E-bits during remote alarm
// - events on LSB toggle and on rollover
// - five forced transmit errors, signal loss overrides BPV and slot data
// - two rx, two tx sixteen-byte slot buffers
// - rx buffer stores sixteen frames per multiframe
// - stop capture on masked pattern, stop event
// - start capture on masked pattern, start event
// - match or mismatch selection per buffer
// - insert code in flagged transmit slots
// - detect code in flagged slots, match event
// - mask one includes bit, zero excludes
// - remote alarm from odd-frame bit three
// - all-ones for one or two double frames
// - all-ones in slot sixteen alarm
// - alternating pattern for 512 bits
// - signal loss after 255 bits without pulse
// - loss clears at one-eighth density window
// - multiframe alarm from alignment word bit
// - auto remote alarm while frame sync lost
// - auto multiframe alarm while alignment lost
// - vector bits seven to four per category
// - vector bits three to zero per category
module emau_top (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire emau_pkg::emau_regreq_s reg_i,
	output logic [7:0] rdata_o,
	input wire logic rx_line_clk_i,
	input wire logic rx_line_pulse_i,
	input wire emau_pkg::emau_rxslot_s rx_slot_i,
	input wire logic rx_nfas_valid_i,
	input wire logic [7:0] rx_nfas_i,
	input wire logic rx_ebit_valid_i,
	input wire logic rx_ebit_i,
	input wire logic rx_mas_valid_i,
	input wire logic [7:0] rx_mas_i,
	input wire logic frame_sync_lost_i,
	input wire logic multiframe_align_lost_i,
	input wire logic [7:0] ext_cat_evt_i,
	input wire logic tx_in_valid_i,
	output logic tx_in_ready_o,
	input wire logic [4:0] tx_in_slot_i,
	input wire logic [3:0] tx_in_frame_i,
	input wire logic [7:0] tx_in_data_i,
	output logic tx_out_valid_o,
	input wire logic tx_out_ready_i,
	output logic [7:0] tx_out_data_o,
	output logic force_bipolar_violation_o,
	output logic force_crc_error_o,
	output logic force_frame_align_error_o,
	output logic force_odd_frame_word_error_o,
	output logic force_signal_loss_o,
	output logic tx_remote_alarm_o,
	output logic tx_mf_alarm_o,
	output emau_pkg::emau_alarm_s alarm_o
);
	typedef struct packed {
		logic [1:0] lclk_sync;
		logic [1:0] lpulse_sync;
		logic lclk_d;
		logic [7:0] mode, ins, det, dmask, mask3, errins, bufctl, vector, recnt, rdata;
		logic [31:0][7:0] slotctl;
		logic [1:0][15:0][7:0] txbuf;
		logic [1:0][15:0][7:0] rxbuf;
		logic [1:0] rec;
		logic [1:0][3:0] wp;
		logic [10:0] ones_run;
		logic [10:0] alt_run;
		logic prev_bit;
		logic [7:0] zero_run;
		logic [7:0] win_cnt;
		logic [7:0] win_ones;
		logic win_act;
		emau_pkg::emau_alarm_s remote_alarm_bit;
	} emau_state_s;
	emau_state_s q, n;

	logic bit_stb, line_bit, hit, vec_clr, re_inc, push;
	logic [7:0] ctl, push_data, cat_evt;
	logic [10:0] ais_lim;

	emau_fifo #(.W(8), .D(8)) u_txfifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.in_valid_i(tx_in_valid_i),
		.in_ready_o(tx_in_ready_o),
		.in_data_i(push_data),
		.out_valid_o(tx_out_valid_o),
		.out_ready_i(tx_out_ready_i),
		.out_data_o(tx_out_data_o)
	);

	// BPV insertion belongs to the line coder, so forced loss suppresses it
	assign force_bipolar_violation_o = q.errins[emau_pkg::ERR_BPV] & ~q.errins[emau_pkg::ERR_LOS];
	assign force_crc_error_o = q.errins[emau_pkg::ERR_CRC];
	assign force_frame_align_error_o = q.errins[emau_pkg::ERR_FAS];
	assign force_odd_frame_word_error_o = q.errins[emau_pkg::ERR_NFAS];
	assign force_signal_loss_o = q.errins[emau_pkg::ERR_LOS];
	// automatic alarms follow the sync inputs directly, no latency
	assign tx_remote_alarm_o = q.mode[emau_pkg::MODE_TALM]
		| (~q.mode[emau_pkg::MODE_AUTO_REMOTE_ALARM_N_N] & frame_sync_lost_i);
	assign tx_mf_alarm_o = q.mode[emau_pkg::MODE_TY]
		| (~q.mode[emau_pkg::MODE_AUTO_MULTIFRAME_ALARM_N_N] & multiframe_align_lost_i);
	assign alarm_o = q.remote_alarm_bit;
	assign rdata_o = q.rdata;
	assign push = tx_in_valid_i & tx_in_ready_o;

	always_comb begin
		n = q;
		cat_evt = ext_cat_evt_i;
		// line pins: two flops, edge detect only on the second
		n.lclk_sync = {q.lclk_sync[0], rx_line_clk_i};
		n.lpulse_sync = {q.lpulse_sync[0], rx_line_pulse_i};
		n.lclk_d = q.lclk_sync[1];
		bit_stb = q.lclk_sync[1] & ~q.lclk_d;
		line_bit = q.lpulse_sync[1];
		ais_lim = q.mode[emau_pkg::MODE_AIS2] ? emau_pkg::AIS_BITS_2 : emau_pkg::AIS_BITS_1;

		// unframed line alarms, one step per recovered bit
		if (bit_stb) begin
			n.prev_bit = line_bit;
			n.ones_run = !line_bit ? 11'h000 : (&q.ones_run ? q.ones_run : q.ones_run + 11'h001);
			n.remote_alarm_bit.ais = (n.ones_run >= ais_lim);
			n.alt_run = (line_bit == q.prev_bit) ? 11'h000 : (&q.alt_run ? q.alt_run : q.alt_run + 11'h001);
			n.remote_alarm_bit.aux = (n.alt_run >= emau_pkg::AUX_BITS);
			n.zero_run = line_bit ? 8'h00 : (&q.zero_run ? q.zero_run : q.zero_run + 8'h01);
			if (!q.remote_alarm_bit.los) begin
				n.win_act = 1'b0;
				if (n.zero_run == emau_pkg::LOS_BITS) begin
					n.remote_alarm_bit.los = 1'b1;
				end
			end else if (!q.win_act) begin
				// a recovery window opens only on a pulse
				if (line_bit) begin
					n.win_act = 1'b1;
					n.win_cnt = 8'h01;
					n.win_ones = 8'h01;
				end
			end else begin
				n.win_cnt = q.win_cnt + 8'h01;
				n.win_ones = q.win_ones + {7'h00, line_bit};
				if (n.win_cnt == emau_pkg::LOS_BITS) begin
					n.win_act = 1'b0;
					n.remote_alarm_bit.los = (n.win_ones < emau_pkg::LOS_MIN_ONES);
				end
			end
		end

		// framed alarm bits
		if (rx_nfas_valid_i) begin
			n.remote_alarm_bit.remote = rx_nfas_i[3];
		end
		if (rx_mas_valid_i) begin
			n.remote_alarm_bit.remote_mf = rx_mas_i[6];
		end
		if (rx_slot_i.valid && rx_slot_i.slot == emau_pkg::SLOT_SIG) begin
			n.remote_alarm_bit.ais16 = (rx_slot_i.data == emau_pkg::ALL_ONES);
		end
		if ((n.remote_alarm_bit & ~q.remote_alarm_bit) != '0) begin
			cat_evt[emau_pkg::VEC_ALARM] = 1'b1;
		end

		// remote error counter; each step flips the LSB, hence one event per step
		re_inc = rx_ebit_valid_i & ~rx_ebit_i & q.remote_alarm_bit.remote;
		if (re_inc) begin
			n.recnt = q.recnt + 8'h01;
			cat_evt[emau_pkg::VEC_CIND] = 1'b1;
			if (q.recnt == emau_pkg::RECNT_MAX) begin
				cat_evt[emau_pkg::VEC_COVF] = 1'b1;
			end
		end

		// receive slots: code detect and circular buffers
		ctl = q.slotctl[rx_slot_i.slot];
		hit = (((rx_slot_i.data ^ q.det) & q.dmask) == 8'h00);
		if (rx_slot_i.valid) begin
			if (ctl[emau_pkg::SC_DETECT] && hit && q.mask3[emau_pkg::M3_DATA]) begin
				cat_evt[emau_pkg::VEC_MAINT] = 1'b1;
			end
			for (int b = 0; b < 2; b++) begin
				if (ctl[emau_pkg::SC_RXB0 + b]) begin
					if (!q.bufctl[emau_pkg::BC_BUFFER_ZERO_START_SELECT - 2 * b] && !q.bufctl[emau_pkg::BC_BUFFER_ZERO_STOP_SELECT - 2 * b]) begin
						// plain mode: slot follows the multiframe frame number
						n.rxbuf[b][rx_slot_i.frame] = rx_slot_i.data;
					end else if (q.rec[b]) begin
						n.rxbuf[b][q.wp[b]] = rx_slot_i.data;
						n.wp[b] = q.wp[b] + 4'h1;
						if (q.bufctl[emau_pkg::BC_BUFFER_ZERO_STOP_SELECT - 2 * b]
							&& (hit ^ q.bufctl[emau_pkg::BC_BUFFER_ZERO_STOP_SELECT - 2 * b - 1])) begin
							n.rec[b] = 1'b0;
							cat_evt[emau_pkg::VEC_MAINT] = cat_evt[emau_pkg::VEC_MAINT]
								| q.mask3[emau_pkg::M3_STOP];
						end
					end else if (q.bufctl[emau_pkg::BC_BUFFER_ZERO_START_SELECT - 2 * b]
						&& (hit ^ q.bufctl[emau_pkg::BC_BUFFER_ZERO_START_SELECT - 2 * b - 1])) begin
						n.rec[b] = 1'b1;
						n.rxbuf[b][q.wp[b]] = rx_slot_i.data;
						n.wp[b] = q.wp[b] + 4'h1;
						cat_evt[emau_pkg::VEC_MAINT] = cat_evt[emau_pkg::VEC_MAINT]
							| q.mask3[emau_pkg::M3_START];
					end
				end
			end
		end

		// transmit slot substitution ahead of the FIFO
		push_data = tx_in_data_i;
		if (q.slotctl[tx_in_slot_i][emau_pkg::SC_INSERT]) begin
			push_data = q.ins;
		end else if (q.slotctl[tx_in_slot_i][emau_pkg::SC_TXB0]) begin
			push_data = q.txbuf[0][tx_in_frame_i];
		end else if (q.slotctl[tx_in_slot_i][emau_pkg::SC_TXB0 + 1]) begin
			push_data = q.txbuf[1][tx_in_frame_i];
		end
		if (q.errins[emau_pkg::ERR_LOS]) begin
			push_data = 8'h00;
		end

		// register writes; a counter preset beats a same-cycle increment
		if (reg_i.wr) begin
			if (reg_i.page == emau_pkg::PG_CTL) begin
				if (reg_i.addr == emau_pkg::A_MODE) n.mode = reg_i.wdata;
				if (reg_i.addr == emau_pkg::A_INSERT) n.ins = reg_i.wdata;
				if (reg_i.addr == emau_pkg::A_DETECT) n.det = reg_i.wdata;
				if (reg_i.addr == emau_pkg::A_DMASK) n.dmask = reg_i.wdata;
				if (reg_i.addr == emau_pkg::A_MASK3) n.mask3 = reg_i.wdata;
			end else if (reg_i.page == emau_pkg::PG_ERR) begin
				if (reg_i.addr == emau_pkg::A_ERRINS) n.errins = reg_i.wdata;
				if (reg_i.addr == emau_pkg::A_BUFCTL) begin
					n.bufctl = reg_i.wdata;
					// stop-only capture records at once, start waits for its pattern
					n.rec = {~reg_i.wdata[emau_pkg::BC_BUFFER_ZERO_START_SELECT - 2], ~reg_i.wdata[emau_pkg::BC_BUFFER_ZERO_START_SELECT]};
					n.wp = '0;
				end
			end else if (reg_i.page == emau_pkg::PG_STAT && reg_i.addr == emau_pkg::A_RECNT) begin
				n.recnt = reg_i.wdata;
			end else if (reg_i.page == emau_pkg::PG_SLOT) begin
				n.slotctl[reg_i.addr] = reg_i.wdata;
			end else if (reg_i.page == emau_pkg::PG_TXB0 || reg_i.page == emau_pkg::PG_TXB1) begin
				n.txbuf[reg_i.page == emau_pkg::PG_TXB1][reg_i.addr[3:0]] = reg_i.wdata;
			end
		end

		// register reads; reading the vector clears it but new events still land
		vec_clr = 1'b0;
		if (reg_i.rd) begin
			n.rdata = 8'h00;
			if (reg_i.page == emau_pkg::PG_CTL) begin
				if (reg_i.addr == emau_pkg::A_MODE) n.rdata = q.mode;
				if (reg_i.addr == emau_pkg::A_INSERT) n.rdata = q.ins;
				if (reg_i.addr == emau_pkg::A_DETECT) n.rdata = q.det;
				if (reg_i.addr == emau_pkg::A_DMASK) n.rdata = q.dmask;
				if (reg_i.addr == emau_pkg::A_MASK3) n.rdata = q.mask3;
			end else if (reg_i.page == emau_pkg::PG_ERR) begin
				if (reg_i.addr == emau_pkg::A_ERRINS) n.rdata = q.errins;
				if (reg_i.addr == emau_pkg::A_BUFCTL) n.rdata = q.bufctl;
			end else if (reg_i.page == emau_pkg::PG_STAT) begin
				if (reg_i.addr == emau_pkg::A_RECNT) n.rdata = q.recnt;
				if (reg_i.addr == emau_pkg::A_ALARMS) n.rdata = {2'h0, q.remote_alarm_bit};
				if (reg_i.addr == emau_pkg::A_VECTOR) begin
					n.rdata = q.vector;
					vec_clr = 1'b1;
				end
			end else if (reg_i.page == emau_pkg::PG_SLOT) begin
				n.rdata = q.slotctl[reg_i.addr];
			end else if (reg_i.page == emau_pkg::PG_TXB0 || reg_i.page == emau_pkg::PG_TXB1) begin
				n.rdata = q.txbuf[reg_i.page == emau_pkg::PG_TXB1][reg_i.addr[3:0]];
			end else if (reg_i.page == emau_pkg::PG_RXB0 || reg_i.page == emau_pkg::PG_RXB1) begin
				n.rdata = q.rxbuf[reg_i.page == emau_pkg::PG_RXB1][reg_i.addr[3:0]];
			end
		end
		n.vector = (vec_clr ? 8'h00 : q.vector) | cat_evt;
	end

	// single state register; auto alarms start disabled
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.mode <= emau_pkg::RST_MODE;
			q.mask3 <= emau_pkg::RST_MASK3;
		end else begin
			q <= n;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	wire re_wr = reg_i.wr && reg_i.page == emau_pkg::PG_STAT && reg_i.addr == emau_pkg::A_RECNT;

	sequence s_slot16_ones;
		rx_slot_i.valid && rx_slot_i.slot == emau_pkg::SLOT_SIG && rx_slot_i.data == emau_pkg::ALL_ONES;
	endsequence
	sequence s_quiet_line;
		bit_stb && !line_bit && q.zero_run == 8'hFE && !q.remote_alarm_bit.los;
	endsequence

	property p_recnt_inc;
		re_inc && !re_wr |=> q.recnt == $past(q.recnt) + 8'h01;
	endproperty
	a_recnt_inc: assert property (p_recnt_inc) else $error("remote error counter missed a step");

	property p_recnt_ovf;
		re_inc && !re_wr && q.recnt == 8'hFF |=> q.recnt == 8'h00 && q.vector[4] && q.vector[5];
	endproperty
	a_recnt_ovf: assert property (p_recnt_ovf) else $error("rollover did not flag overflow");

	property p_force_signal_loss_zero;
		push && q.errins[emau_pkg::ERR_LOS] |-> push_data == 8'h00 && !force_bipolar_violation_o;
	endproperty
	a_force_signal_loss_zero: assert property (p_force_signal_loss_zero) else $error("forced loss not silent");

	property p_insert;
		push && !q.errins[emau_pkg::ERR_LOS] && q.slotctl[tx_in_slot_i][7] |-> push_data == q.ins;
	endproperty
	a_insert: assert property (p_insert) else $error("insert code not sent");

	property p_match;
		rx_slot_i.valid && ctl[6] && hit && q.mask3[0] |=> q.vector[1];
	endproperty
	a_match: assert property (p_match) else $error("data match not flagged");

	property p_store;
		rx_slot_i.valid && ctl[0] && q.bufctl[7] == 1'b0 && q.bufctl[3] == 1'b0 && !reg_i.wr
			|=> q.rxbuf[0][$past(rx_slot_i.frame)] == $past(rx_slot_i.data);
	endproperty
	a_store: assert property (p_store) else $error("buffer zero did not store slot");

	property p_ais16;
		s_slot16_ones |=> q.remote_alarm_bit.ais16 ##1 q.vector[6] || q.remote_alarm_bit.ais16;
	endproperty
	a_ais16: assert property (p_ais16) else $error("slot sixteen all-ones missed");

	property p_los;
		s_quiet_line |=> q.remote_alarm_bit.los;
	endproperty
	a_los: assert property (p_los) else $error("loss of signal not declared");

	property p_auto_rai;
		$rose(frame_sync_lost_i) && !q.mode[4] |-> tx_remote_alarm_o;
	endproperty
	a_auto_rai: assert property (p_auto_rai) else $error("auto remote alarm not sent");

	property p_vec_clear;
		reg_i.rd && reg_i.page == 4'h4 && reg_i.addr == 5'h12 && cat_evt == 8'h00 |=> q.vector == 8'h00;
	endproperty
	a_vec_clear: assert property (p_vec_clear) else $error("vector not cleared on read");
endmodule : emau_top
`default_nettype wire

//--- test/emau_line_model.sv
/* emau_line_model: far-end line source, one line bit every 64 ns.
   assumes the bench picks the pattern: 0 zeros, 1 ones, 2 alternating */
`timescale 1ns/10ps
`default_nettype none
module emau_line_model (
	input wire logic [1:0] mode_i,
	output logic line_clk_o,
	output logic line_pulse_o
);
	logic alt_ff;
	// recovered clock runs free, as a line clock does
	initial begin
		line_clk_o = 1'b0;
		line_pulse_o = 1'b0;
		alt_ff = 1'b0;
	end
	always #32 line_clk_o = ~line_clk_o;
	// change on the falling edge so the rising edge sees a settled level
	always @(negedge line_clk_o) begin
		alt_ff <= ~alt_ff;
		line_pulse_o <= (mode_i == 2'h1) | ((mode_i == 2'h2) & alt_ff);
	end
endmodule : emau_line_model
`default_nettype wire

//--- test/emau_tb.sv
/* tb: register-call tests of emau_top with a far-end line model.
   assumes inputs change on the falling edge and rdata_o holds after a read */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic mclk, rst, nv, ev, ebit, mv, fsl, mfl, tiv, tir, tov, tor, tra, tma, lclk, lpul;
	logic [7:0] rdata, nfas, mas, ext, tdat, tout;
	logic [4:0] tslot, frc;
	logic [3:0] tfrm;
	logic [1:0] lmode;
	emau_pkg::emau_regreq_s req;
	emau_pkg::emau_rxslot_s rxs;
	emau_pkg::emau_alarm_s remote_alarm_bit;
	int error_cnt, checked, cyc;
	emau_top DUT (.mclk_i(mclk), .rst_i(rst), .reg_i(req), .rdata_o(rdata),
		.rx_line_clk_i(lclk), .rx_line_pulse_i(lpul), .rx_slot_i(rxs),
		.rx_nfas_valid_i(nv), .rx_nfas_i(nfas), .rx_ebit_valid_i(ev), .rx_ebit_i(ebit),
		.rx_mas_valid_i(mv), .rx_mas_i(mas), .frame_sync_lost_i(fsl),
		.multiframe_align_lost_i(mfl), .ext_cat_evt_i(ext), .tx_in_valid_i(tiv),
		.tx_in_ready_o(tir), .tx_in_slot_i(tslot), .tx_in_frame_i(tfrm), .tx_in_data_i(tdat),
		.tx_out_valid_o(tov), .tx_out_ready_i(tor), .tx_out_data_o(tout),
		.force_bipolar_violation_o(frc[4]), .force_crc_error_o(frc[3]),
		.force_frame_align_error_o(frc[2]), .force_odd_frame_word_error_o(frc[1]),
		.force_signal_loss_o(frc[0]), .tx_remote_alarm_o(tra), .tx_mf_alarm_o(tma),
		.alarm_o(remote_alarm_bit));
	emau_line_model u_line (.mode_i(lmode), .line_clk_o(lclk), .line_pulse_o(lpul));
	// 125 MHz clock and a hang guard well above the expected run length
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk8
	task automatic chk1(input string n, input logic e, input logic s);
		chk8(n, {7'h00, e}, {7'h00, s});
	endtask : chk1
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	// a trailing idle cycle keeps two calls from driving one strobe in one step
	task automatic wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
		req = '{wr: 1'b1, rd: 1'b0, page: p, addr: a, wdata: d};
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask : wr
	task automatic rdchk(input logic [3:0] p, input logic [4:0] a, input logic [7:0] e, input string n);
		req = '{wr: 1'b0, rd: 1'b1, page: p, addr: a, wdata: 8'h00};
		tick(1);
		req.rd = 1'b0;
		tick(1);
		chk8(n, e, rdata);
	endtask : rdchk
	task automatic slot(input logic [4:0] s, input logic [3:0] f, input logic [7:0] d);
		rxs = '{valid: 1'b1, slot: s, frame: f, data: d};
		tick(1);
		rxs.valid = 1'b0;
		tick(1);
	endtask : slot
	task automatic send_ebit(input logic b);
		ebit = b;
		ev = 1'b1;
		tick(1);
		ev = 1'b0;
		tick(1);
	endtask : send_ebit
	task automatic push(input logic [4:0] s, input logic [3:0] f, input logic [7:0] d);
		tslot = s;
		tfrm = f;
		tdat = d;
		tiv = 1'b1;
		tick(1);
		tiv = 1'b0;
		tick(1);
	endtask : push
	task automatic pop(input logic [7:0] e);
		chk1("tx_out_valid", 1'b1, tov);
		chk8("tx_out_data", e, tout);
		tor = 1'b1;
		tick(1);
		tor = 1'b0;
		tick(1);
	endtask : pop
	// each bit of the line model lasts eight clock cycles
	task automatic bits(input int n);
		tick(n * 8);
	endtask : bits
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{nv, ev, ebit, mv, fsl, mfl, tiv, tor} = 8'h00;
		{nfas, mas, ext, tdat, tslot, tfrm} = 41'h0;
		req = '0;
		rxs = '0;
		lmode = 2'h1;
		error_cnt = 0;
		checked = 0;
		cyc = 0;
		tick(4);
		rst = 1'b0;
		tick(1);
		rdchk(emau_pkg::PG_CTL, emau_pkg::A_MODE, emau_pkg::RST_MODE, "mode");
		rdchk(emau_pkg::PG_CTL, emau_pkg::A_MASK3, emau_pkg::RST_MASK3, "mask3");
		rdchk(4'h3, 5'h01, 8'h00, "unmapped");
		chk1("tx_in_ready", 1'b1, tir);
		wr(emau_pkg::PG_CTL, emau_pkg::A_INSERT, 8'h5A);
		rdchk(emau_pkg::PG_CTL, emau_pkg::A_INSERT, 8'h5A, "insert");
		wr(emau_pkg::PG_CTL, emau_pkg::A_DETECT, 8'hA5);
		rdchk(emau_pkg::PG_CTL, emau_pkg::A_DETECT, 8'hA5, "detect");
		wr(emau_pkg::PG_CTL, emau_pkg::A_DMASK, 8'hF0);
		rdchk(emau_pkg::PG_CTL, emau_pkg::A_DMASK, 8'hF0, "dmask");
		$display("test reset_regs done");
		// line alarms: ones, then zeros, then ones, then alternating
		bits(400);
		chk1("ais_early", 1'b0, remote_alarm_bit.ais);
		bits(200);
		chk1("ais", 1'b1, remote_alarm_bit.ais);
		lmode = 2'h0;
		bits(240);
		chk1("los_early", 1'b0, remote_alarm_bit.los);
		bits(30);
		chk1("los", 1'b1, remote_alarm_bit.los);
		lmode = 2'h1;
		bits(300);
		chk1("los_clear", 1'b0, remote_alarm_bit.los);
		lmode = 2'h2;
		bits(450);
		chk1("aux_early", 1'b0, remote_alarm_bit.aux);
		bits(150);
		chk1("aux", 1'b1, remote_alarm_bit.aux);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h40, "vector_alarm");
		$display("test line_alarms done");
		for (int i = 0; i < 5; i++) begin
			wr(emau_pkg::PG_ERR, emau_pkg::A_ERRINS, 8'h01 << i);
			chk8("force", 8'h01 << i, {3'h0, frc});
		end
		wr(emau_pkg::PG_ERR, emau_pkg::A_ERRINS, 8'h11);
		chk8("force_los_wins", 8'h01, {3'h0, frc});
		push(5'h04, 4'h0, 8'h55);
		pop(8'h00);
		wr(emau_pkg::PG_ERR, emau_pkg::A_ERRINS, 8'h00);
		$display("test error_insert done");
		ext = 8'h8D;
		tick(1);
		ext = 8'h00;
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h8D, "vector_ext");
		wr(emau_pkg::PG_CTL, emau_pkg::A_MODE, 8'h00);
		fsl = 1'b1;
		tick(1);
		chk1("auto_remote", 1'b1, tra);
		fsl = 1'b0;
		mfl = 1'b1;
		tick(1);
		chk1("auto_remote_off", 1'b0, tra);
		chk1("auto_mf", 1'b1, tma);
		wr(emau_pkg::PG_CTL, emau_pkg::A_MODE, 8'h18);
		chk1("auto_mf_disabled", 1'b0, tma);
		mfl = 1'b0;
		$display("test auto_alarms done");
		nfas = 8'h08;
		nv = 1'b1;
		tick(1);
		nv = 1'b0;
		tick(2);
		chk1("remote", 1'b1, remote_alarm_bit.remote);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h40, "vector_remote");
		wr(emau_pkg::PG_STAT, emau_pkg::A_RECNT, 8'hFE);
		send_ebit(1'b1);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_RECNT, 8'hFE, "recnt_ok_ebit");
		send_ebit(1'b0);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_RECNT, 8'hFF, "recnt_inc");
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h20, "vector_ind");
		send_ebit(1'b0);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_RECNT, 8'h00, "recnt_wrap");
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h30, "vector_ovf");
		nfas = 8'h00;
		nv = 1'b1;
		tick(1);
		nv = 1'b0;
		tick(2);
		chk1("remote_off", 1'b0, remote_alarm_bit.remote);
		send_ebit(1'b0);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_RECNT, 8'h00, "recnt_no_alarm");
		mas = 8'h40;
		mv = 1'b1;
		tick(1);
		mv = 1'b0;
		tick(2);
		chk1("remote_mf", 1'b1, remote_alarm_bit.remote_mf);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h40, "vector_mf");
		$display("test remote_counter done");
		// detect on slot 5 only, upper nibble compared
		wr(emau_pkg::PG_SLOT, 5'h05, 8'h40);
		wr(emau_pkg::PG_CTL, emau_pkg::A_MASK3, 8'h01);
		slot(5'h05, 4'h0, 8'hAF);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h02, "vector_match");
		slot(5'h05, 4'h0, 8'h5F);
		slot(5'h06, 4'h0, 8'hA5);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h00, "vector_nomatch");
		$display("test detect done");
		wr(emau_pkg::PG_SLOT, 5'h09, 8'h01);
		for (int f = 0; f < 16; f++)
			slot(5'h09, 4'(f), 8'hC0 + 8'(f));
		slot(5'h09, 4'h0, 8'h11);
		wr(emau_pkg::PG_SLOT, 5'h09, 8'h00);
		slot(5'h09, 4'h1, 8'h22);
		for (int f = 0; f < 16; f++)
			rdchk(emau_pkg::PG_RXB0, 5'(f), (f == 0) ? 8'h11 : 8'hC0 + 8'(f), "rxbuf0");
		$display("test rx_buffer done");
		slot(emau_pkg::SLOT_SIG, 4'h0, 8'hFF);
		chk1("ais16", 1'b1, remote_alarm_bit.ais16);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h40, "vector_ais16");
		// buffer zero starts on a match and stops on a mismatch
		wr(emau_pkg::PG_SLOT, 5'h09, 8'h01);
		wr(emau_pkg::PG_CTL, emau_pkg::A_MASK3, 8'h06);
		wr(emau_pkg::PG_ERR, emau_pkg::A_BUFCTL, 8'h8C);
		slot(5'h09, 4'h0, 8'h11);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h00, "vector_no_start");
		slot(5'h09, 4'h0, 8'hA1);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h02, "vector_start");
		slot(5'h09, 4'h0, 8'hA2);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h00, "vector_no_stop");
		slot(5'h09, 4'h0, 8'h33);
		rdchk(emau_pkg::PG_STAT, emau_pkg::A_VECTOR, 8'h02, "vector_stop");
		slot(5'h09, 4'h0, 8'h44);
		rdchk(emau_pkg::PG_RXB0, 5'h00, 8'hA1, "cap0");
		rdchk(emau_pkg::PG_RXB0, 5'h01, 8'hA2, "cap1");
		rdchk(emau_pkg::PG_RXB0, 5'h02, 8'h33, "cap2");
		rdchk(emau_pkg::PG_RXB0, 5'h03, 8'hC3, "cap_after_stop");
		wr(emau_pkg::PG_SLOT, 5'h09, 8'h00);
		wr(emau_pkg::PG_ERR, emau_pkg::A_BUFCTL, 8'h00);
		$display("test capture done");
		wr(emau_pkg::PG_SLOT, 5'h03, 8'h80);
		push(5'h03, 4'h0, 8'h11);
		pop(8'h5A);
		wr(emau_pkg::PG_TXB0, 5'h02, 8'h77);
		wr(emau_pkg::PG_SLOT, 5'h0A, 8'h04);
		push(5'h0A, 4'h2, 8'h11);
		pop(8'h77);
		for (int i = 0; i < 8; i++)
			push(5'h04, 4'h0, 8'(i));
		chk1("tx_in_ready_full", 1'b0, tir);
		for (int i = 0; i < 8; i++)
			pop(8'(i));
		chk1("tx_out_valid_empty", 1'b0, tov);
		$display("test transmit done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
